// *** dv/fgc_regs_bench.sv ***
`default_nettype none
module fgc_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fgc_pkg::*;

  typedef struct {
    logic         cur;
    fgc_word_type gain;
    fgc_word_type off;
    fgc_word_type rd;
    fgc_word_type res;
  } fgc_conv_row_type;

  logic          clk_i = 1'b0;
  logic          reset_i = 1'b1;
  logic          wb_cyc = 1'b0;
  logic          wb_stb = 1'b0;
  logic          wb_we = 1'b0;
  logic [10:0]   wb_adr = 11'h000;
  logic [3:0]    wb_sel = 4'h0;
  logic [31:0]   wb_dat = 32'h0000_0000;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  fgc_word_type  therm = 16'h0000;
  fgc_word_type  cur_rd = 16'h0000;
  fgc_word_type  volt = 16'h1000;
  logic          t_smp = 1'b0;
  logic          c_smp = 1'b0;
  logic          v_smp = 1'b0;
  fgc_word_type  delta = 16'h0064;
  fgc_word_type  temp_result_o;
  fgc_word_type  current_result_o;
  logic [7:0]    hot_o;
  logic [7:0]    cold_o;
  logic [7:0]    comp_o;
  logic          empty_event_o;
  fgc_learn_type learn_mode_o;
  logic          irq_o;
  fgc_word_type  q;
  int            failures = 0;
  int            cmp_count = 0;

  // products are shifted arithmetically, so -1 x tiny gain gives -1
  fgc_conv_row_type rows [9] = '{
    '{1'b0, 16'h4000, 16'h0000, 16'h1234, 16'h1234},
    '{1'b0, 16'h2000, 16'h0010, 16'h1000, 16'h0820},
    '{1'b0, 16'hc000, 16'hfff0, 16'h0100, 16'hfee0},
    '{1'b0, 16'h8000, 16'h0000, 16'h0003, 16'hfffa},
    '{1'b1, 16'h4000, 16'h0000, 16'hff00, 16'hff00},
    '{1'b1, 16'h6000, 16'h0005, 16'h0100, 16'h018a},
    '{1'b1, 16'he000, 16'hfffe, 16'hfe00, 16'h00fc},
    '{1'b1, 16'h4000, 16'h7fff, 16'h0001, 16'hffff},
    '{1'b1, 16'h0001, 16'h0000, 16'hffff, 16'hffff}};
  fgc_index_type rst_idx [13] = '{IDX_TEMP_GAIN, IDX_TEMP_OFFSET,
    IDX_CUR_GAIN, IDX_CUR_OFFSET, IDX_RTABLE_20, IDX_EMPTY_AVG,
    IDX_NOM_RCOMP, IDX_TEMP_COEF, IDX_EMPTY_THR, IDX_RTABLE_30,
    IDX_IRQ_STATUS, IDX_IRQ_ENABLE, IDX_EMPTY_STATE};
  fgc_word_type rst_val [13] = '{16'h4000, 16'h0000, 16'h4000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h9c5c, 16'h0000,
    16'h0000, 16'h0000, 16'h0001};

  fgc_regs dut (
    .clk_i                           (clk_i),
    .reset_i                         (reset_i),
    .wb_cyc_i                        (wb_cyc),
    .wb_stb_i                        (wb_stb),
    .wb_we_i                         (wb_we),
    .wb_adr_i                        (wb_adr),
    .wb_sel_i                        (wb_sel),
    .wb_dat_i                        (wb_dat),
    .wb_dat_o                        (wb_dat_o),
    .wb_ack_o                        (wb_ack_o),
    .thermistor_input_reading_i      (therm),
    .temp_sample_i                   (t_smp),
    .current_reading_i               (cur_rd),
    .current_sample_i                (c_smp),
    .cell_voltage_i                  (volt),
    .voltage_sample_i                (v_smp),
    .learn_delta_i                   (delta),
    .temp_result_o                   (temp_result_o),
    .current_result_o                (current_result_o),
    .hot_coefficient_o               (hot_o),
    .cold_coefficient_o              (cold_o),
    .nominal_resistance_comp_field_o (comp_o),
    .empty_event_o                   (empty_event_o),
    .learn_mode_o                    (learn_mode_o),
    .irq_o                           (irq_o)
  );

  always #10 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // entered just after a rising edge; leaves one idle cycle behind it
  task automatic wb(input logic we, input fgc_index_type idx,
                    input fgc_word_type d, input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= {idx, 2'b00};
    wb_sel <= sel;
    wb_dat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    chk("wb_ack", 1'b1, wb_ack_o);
    q = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rdchk(input string what, input fgc_index_type idx,
                       input fgc_word_type exp);
    wb(1'b0, idx, 16'h0000, 4'hf);
    chk(what, exp, q);
  endtask : rdchk

  task automatic smp(input int kind, input fgc_word_type v);
    t_smp  <= (kind == 0);
    c_smp  <= (kind == 1);
    v_smp  <= (kind == 2);
    therm  <= (kind == 0) ? v : therm;
    cur_rd <= (kind == 1) ? v : cur_rd;
    volt   <= (kind == 2) ? v : volt;
    @(posedge clk_i);
    t_smp <= 1'b0;
    c_smp <= 1'b0;
    v_smp <= 1'b0;
    @(posedge clk_i);
  endtask : smp

  task automatic do_reset;
    reset_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wb(1'b1, rows[i].cur ? IDX_CUR_GAIN : IDX_TEMP_GAIN, rows[i].gain,
         4'h3);
      wb(1'b1, rows[i].cur ? IDX_CUR_OFFSET : IDX_TEMP_OFFSET, rows[i].off,
         4'h3);
      smp(rows[i].cur ? 1 : 0, rows[i].rd);
      chk("conv", rows[i].res,
          rows[i].cur ? current_result_o : temp_result_o);
    end
    // second reset in mid-run, after the gains were changed
    do_reset();
    foreach (rst_idx[i])
      rdchk("reset_value", rst_idx[i], rst_val[i]);
    chk("irq_after_reset", 1'b0, irq_o);
    smp(1, 16'h03e8);
    chk("current_default", 16'h03e8, current_result_o);
    smp(0, 16'h1900);
    chk("temp_default", 16'h1900, temp_result_o);
    wb(1'b1, IDX_IRQ_ENABLE, 16'h0007, 4'h3);
    smp(2, 16'd3120);
    chk("no_empty_at_thr", 1'b0, empty_event_o);
    smp(2, 16'd3119);
    chk("empty_event", 1'b1, empty_event_o);
    chk("learn_gain", FGC_LEARN_GAIN, learn_mode_o);
    @(posedge clk_i);
    chk("empty_pulse_end", 1'b0, empty_event_o);
    rdchk("status", IDX_IRQ_STATUS, 16'h0005);
    chk("irq_set", 1'b1, irq_o);
    rdchk("avg", IDX_EMPTY_AVG, 16'h00fa);
    rdchk("table20", IDX_RTABLE_20, 16'h0032);
    rdchk("table30", IDX_RTABLE_30, 16'h0032);
    rdchk("state", IDX_EMPTY_STATE, 16'h0002);
    smp(2, 16'd3000);
    chk("disarmed", 1'b0, empty_event_o);
    smp(2, 16'd3680);
    rdchk("no_rearm", IDX_IRQ_STATUS, 16'h0005);
    smp(2, 16'd3681);
    rdchk("rearm", IDX_IRQ_STATUS, 16'h0007);
    wb(1'b1, IDX_IRQ_CLEAR, 16'h0007, 4'h3);
    rdchk("cleared", IDX_IRQ_STATUS, 16'h0000);
    chk("irq_clear", 1'b0, irq_o);
    wb(1'b1, IDX_IRQ_STATUS, 16'hffff, 4'h3);
    rdchk("status_ro", IDX_IRQ_STATUS, 16'h0000);
    rdchk("clear_reads_0", IDX_IRQ_CLEAR, 16'h0000);
    wb(1'b1, IDX_IRQ_ENABLE, 16'h0000, 4'h3);
    smp(2, 16'd3000);
    chk("second_empty", 1'b1, empty_event_o);
    chk("irq_masked", 1'b0, irq_o);
    wb(1'b1, IDX_IRQ_ENABLE, 16'h0001, 4'h3);
    chk("irq_unmasked", 1'b1, irq_o);
    rdchk("avg_run", IDX_EMPTY_AVG, 16'h01b5);
    rdchk("table20_acc", IDX_RTABLE_20, 16'h0064);
    wb(1'b1, IDX_IRQ_CLEAR, 16'h0007, 4'h3);
    chk("irq_clear2", 1'b0, irq_o);
    smp(2, 16'd3700);
    smp(1, 16'hfc18);
    smp(2, 16'd3000);
    chk("learn_offset", FGC_LEARN_OFFSET, learn_mode_o);
    wb(1'b1, IDX_TEMP_COEF, 16'ha55a, 4'h3);
    chk("hot", 8'ha5, hot_o);
    chk("cold", 8'h5a, cold_o);
    wb(1'b1, IDX_TEMP_COEF, 16'h1234, 4'h1);
    rdchk("coef_lane", IDX_TEMP_COEF, 16'ha534);
    wb(1'b1, IDX_NOM_RCOMP, 16'hbeef, 4'h3);
    rdchk("comp_reg", IDX_NOM_RCOMP, 16'h00ef);
    chk("comp_out", 8'hef, comp_o);
    wb(1'b1, IDX_EMPTY_THR, 16'h1357, 4'h3);
    rdchk("thr_rw", IDX_EMPTY_THR, 16'h1357);
    wb(1'b1, IDX_EMPTY_AVG, 16'h8001, 4'h3);
    rdchk("avg_rw", IDX_EMPTY_AVG, 16'h8001);
    wb(1'b1, 9'h030, 16'hffff, 4'h3);
    rdchk("unmapped", 9'h030, 16'h0000);
    complete_run();
  end
endmodule : fgc_regs_bench
`default_nettype wire

// *** verilog/fgc_pkg.sv ***
`default_nettype none
package fgc_pkg;
  typedef logic [15:0] fgc_word_type;
  typedef logic [8:0]  fgc_index_type;

  // register indexes; byte address is four times the index
  localparam fgc_index_type IDX_TEMP_GAIN    = 9'h02c;
  localparam fgc_index_type IDX_TEMP_OFFSET  = 9'h02d;
  localparam fgc_index_type IDX_CUR_GAIN     = 9'h02e;
  localparam fgc_index_type IDX_CUR_OFFSET   = 9'h02f;
  localparam fgc_index_type IDX_RTABLE_20    = 9'h032;
  localparam fgc_index_type IDX_EMPTY_AVG    = 9'h036;
  localparam fgc_index_type IDX_NOM_RCOMP    = 9'h038;
  localparam fgc_index_type IDX_TEMP_COEF    = 9'h039;
  localparam fgc_index_type IDX_EMPTY_THR    = 9'h03a;
  localparam fgc_index_type IDX_RTABLE_30    = 9'h042;
  localparam fgc_index_type IDX_TEMP_RESULT  = 9'h050;
  localparam fgc_index_type IDX_CUR_RESULT   = 9'h051;
  localparam fgc_index_type IDX_IRQ_STATUS   = 9'h052;
  localparam fgc_index_type IDX_IRQ_CLEAR    = 9'h053;
  localparam fgc_index_type IDX_IRQ_ENABLE   = 9'h054;
  localparam fgc_index_type IDX_EMPTY_STATE  = 9'h055;

  // values after reset
  localparam fgc_word_type RST_TEMP_GAIN   = 16'h4000;
  localparam fgc_word_type RST_TEMP_OFFSET = 16'h0000;
  localparam fgc_word_type RST_CUR_GAIN    = 16'h4000;
  localparam fgc_word_type RST_CUR_OFFSET  = 16'h0000;
  localparam fgc_word_type RST_RTABLE      = 16'h0000;
  localparam fgc_word_type RST_EMPTY_AVG   = 16'h0000;
  localparam fgc_word_type RST_NOM_RCOMP   = 16'h0000;
  localparam fgc_word_type RST_TEMP_COEF   = 16'h0000;
  // 312 x 10 mV in 15:7, 92 x 40 mV in 6:0
  localparam fgc_word_type RST_EMPTY_THR   = 16'h9c5c;

  // field positions and scaling
  localparam int GAIN_SHIFT     = 14;
  localparam int EMPTY_LSB      = 7;
  localparam int EMPTY_STEP_MV  = 10;
  localparam int RECOV_STEP_MV  = 40;
  localparam int AVG_SHIFT      = 2;
  localparam int TABLE_LO_DEGC  = 20;
  localparam int TABLE_SPAN     = 10;
  localparam int LEARN_MARGIN   = 200;

  // interrupt status bits
  localparam int IRQ_EMPTY   = 0;
  localparam int IRQ_RECOVER = 1;
  localparam int IRQ_LEARN   = 2;
  localparam int IRQ_BITS    = 3;

  typedef enum logic [1:0] {
    FGC_LEARN_NONE   = 2'b00,
    FGC_LEARN_GAIN   = 2'b01,
    FGC_LEARN_OFFSET = 2'b10,
    FGC_LEARN_BOTH   = 2'b11
  } fgc_learn_type;
endpackage : fgc_pkg
`default_nettype wire

// *** verilog/fgc_regs.sv ***
`default_nettype none
module fgc_regs (
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [10:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire fgc_pkg::fgc_word_type thermistor_input_reading_i,
  input  wire logic                 temp_sample_i,
  input  wire fgc_pkg::fgc_word_type current_reading_i,
  input  wire logic                 current_sample_i,
  input  wire fgc_pkg::fgc_word_type cell_voltage_i,
  input  wire logic                 voltage_sample_i,
  input  wire fgc_pkg::fgc_word_type learn_delta_i,
  output fgc_pkg::fgc_word_type      temp_result_o,
  output fgc_pkg::fgc_word_type      current_result_o,
  output logic      [7:0]           hot_coefficient_o,
  output logic      [7:0]           cold_coefficient_o,
  output logic      [7:0]           nominal_resistance_comp_field_o,
  output logic                      empty_event_o,
  output fgc_pkg::fgc_learn_type     learn_mode_o,
  output logic                      irq_o
);
  import fgc_pkg::*;

  // signed scaling shared by the temperature and current paths
  function automatic fgc_word_type fgc_scale(input fgc_word_type raw,
                                             input fgc_word_type gain,
                                             input fgc_word_type off);
    logic signed [31:0] prod;
    logic signed [31:0] sum;
    prod = $signed(raw) * $signed(gain);
    sum  = (prod >>> GAIN_SHIFT) + ($signed({{16{off[15]}}, off}) <<< 1);
    return sum[15:0];
  endfunction : fgc_scale

  // byte-lane merge for the 16-bit registers
  function automatic fgc_word_type fgc_merge(input fgc_word_type old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
    fgc_word_type res;
    res = old;
    if (sel[0]) res[7:0] = wdat[7:0];
    if (sel[1]) res[15:8] = wdat[15:8];
    return res;
  endfunction : fgc_merge

  fgc_word_type         temp_gain_value_r;
  fgc_word_type         temp_offset_value_r;
  fgc_word_type         current_gain_value_r;
  fgc_word_type         current_offset_value_r;
  fgc_word_type         rtable20_r;
  fgc_word_type         rtable30_r;
  fgc_word_type         empty_avg_r;
  logic [7:0]           nom_rcomp_r;
  fgc_word_type         temp_coef_r;
  fgc_word_type         empty_thr_r;
  fgc_word_type         temp_res_r;
  fgc_word_type         cur_res_r;
  logic [IRQ_BITS-1:0]  irq_status_r;
  logic [IRQ_BITS-1:0]  irq_enable_r;
  logic                 armed_r;
  logic                 empty_evt_r;
  fgc_learn_type        learn_mode_r;
  logic                 ack_r;
  logic [31:0]          dat_r;

  // bus decode
  wire fgc_index_type   idx       = wb_adr_i[10:2];
  wire                  req       = wb_cyc_i & wb_stb_i;
  wire                  commit    = req & ack_r & wb_we_i;
  wire                  wr_temp_gain_value  = commit & (idx == IDX_TEMP_GAIN);
  wire                  wr_temp_offset_value   = commit & (idx == IDX_TEMP_OFFSET);
  wire                  wr_current_gain_value  = commit & (idx == IDX_CUR_GAIN);
  wire                  wr_current_offset_value   = commit & (idx == IDX_CUR_OFFSET);
  wire                  wr_tab20  = commit & (idx == IDX_RTABLE_20);
  wire                  wr_tab30  = commit & (idx == IDX_RTABLE_30);
  wire                  wr_avg    = commit & (idx == IDX_EMPTY_AVG);
  wire                  wr_rcomp  = commit & (idx == IDX_NOM_RCOMP);
  wire                  wr_tcoef  = commit & (idx == IDX_TEMP_COEF);
  wire                  wr_thr    = commit & (idx == IDX_EMPTY_THR);
  wire                  wr_clr    = commit & (idx == IDX_IRQ_CLEAR);
  wire                  wr_en     = commit & (idx == IDX_IRQ_ENABLE);

  // empty detection thresholds in mV
  wire fgc_word_type    empty_mv   =
    16'(empty_thr_r[15:EMPTY_LSB] * EMPTY_STEP_MV);
  wire fgc_word_type    recover_mv =
    16'(empty_thr_r[EMPTY_LSB-1:0] * RECOV_STEP_MV);
  wire                  below_empty  = cell_voltage_i < empty_mv;
  wire                  above_recov  = cell_voltage_i > recover_mv;
  // detection is one-shot until the cell recovers
  wire                  empty_hit   = voltage_sample_i & armed_r &
                                      below_empty;
  wire                  recover_hit = voltage_sample_i & ~armed_r &
                                      above_recov;

  // running average pivot and learn direction
  wire signed [16:0]    cur_diff  = $signed({cur_res_r[15], cur_res_r}) -
                                    $signed({empty_avg_r[15], empty_avg_r});
  wire fgc_word_type    avg_nxt   =
    16'($signed(empty_avg_r) + (cur_diff >>> AVG_SHIFT));
  wire fgc_learn_type   learn_nxt =
    (cur_diff >  17'sd200) ? FGC_LEARN_GAIN :
    (cur_diff < -17'sd200) ? FGC_LEARN_OFFSET :
                             FGC_LEARN_BOTH;

  // split the learn correction between the 20 and 30 degree entries
  wire signed [7:0]     temp_degc = $signed(temp_res_r[15:8]);
  wire signed [31:0]    weight    =
    (temp_degc <= 8'sd20) ? 32'sd0 :
    (temp_degc >= 8'sd30) ? 32'sd10 :
                            32'(temp_degc) - 32'sd20;
  wire signed [31:0]    delta     = 32'($signed(learn_delta_i));
  wire signed [31:0]    part30    = (delta * weight) / 32'sd10;
  wire signed [31:0]    part20    = delta - part30;
  wire fgc_word_type    tab20_nxt = rtable20_r + part20[15:0];
  wire fgc_word_type    tab30_nxt = rtable30_r + part30[15:0];

  // interrupt events; a set in the clearing cycle survives
  wire [IRQ_BITS-1:0]   irq_set   = {empty_hit, recover_hit, empty_hit};
  wire [IRQ_BITS-1:0]   irq_clr   = wr_clr ? wb_dat_i[IRQ_BITS-1:0] :
                                             '0;
  wire [IRQ_BITS-1:0]   irq_nxt   = (irq_status_r & ~irq_clr) | irq_set;

  // read mux; unmapped addresses read zero and still get ack
  fgc_word_type         rd_word;
  always_comb begin
    case (idx)
      IDX_TEMP_GAIN:   rd_word = temp_gain_value_r;
      IDX_TEMP_OFFSET: rd_word = temp_offset_value_r;
      IDX_CUR_GAIN:    rd_word = current_gain_value_r;
      IDX_CUR_OFFSET:  rd_word = current_offset_value_r;
      IDX_RTABLE_20:   rd_word = rtable20_r;
      IDX_RTABLE_30:   rd_word = rtable30_r;
      IDX_EMPTY_AVG:   rd_word = empty_avg_r;
      IDX_NOM_RCOMP:   rd_word = {8'h00, nom_rcomp_r};
      IDX_TEMP_COEF:   rd_word = temp_coef_r;
      IDX_EMPTY_THR:   rd_word = empty_thr_r;
      IDX_TEMP_RESULT: rd_word = temp_res_r;
      IDX_CUR_RESULT:  rd_word = cur_res_r;
      IDX_IRQ_STATUS:  rd_word = 16'(irq_status_r);
      IDX_IRQ_ENABLE:  rd_word = 16'(irq_enable_r);
      IDX_EMPTY_STATE: rd_word = {13'h0000, learn_mode_r, armed_r};
      default:         rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      dat_r <= {16'h0000, rd_word};
    end
  end

  // software writes have priority over learn updates of the same word
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      temp_gain_value_r      <= RST_TEMP_GAIN;
      temp_offset_value_r    <= RST_TEMP_OFFSET;
      current_gain_value_r   <= RST_CUR_GAIN;
      current_offset_value_r <= RST_CUR_OFFSET;
      nom_rcomp_r            <= RST_NOM_RCOMP[7:0];
      temp_coef_r            <= RST_TEMP_COEF;
      empty_thr_r            <= RST_EMPTY_THR;
    end else begin
      if (wr_temp_gain_value) temp_gain_value_r <= fgc_merge(temp_gain_value_r,
                                                   wb_dat_i, wb_sel_i);
      if (wr_temp_offset_value) temp_offset_value_r <= fgc_merge(temp_offset_value_r,
                                                    wb_dat_i, wb_sel_i);
      if (wr_current_gain_value) current_gain_value_r <= fgc_merge(current_gain_value_r,
                                                      wb_dat_i, wb_sel_i);
      if (wr_current_offset_value) current_offset_value_r <= fgc_merge(
                     current_offset_value_r, wb_dat_i, wb_sel_i);
      if (wr_rcomp && wb_sel_i[0]) nom_rcomp_r <= wb_dat_i[7:0];
      if (wr_tcoef) temp_coef_r <= fgc_merge(temp_coef_r, wb_dat_i,
                                             wb_sel_i);
      if (wr_thr) empty_thr_r <= fgc_merge(empty_thr_r, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rtable20_r  <= RST_RTABLE;
      rtable30_r  <= RST_RTABLE;
      empty_avg_r <= RST_EMPTY_AVG;
    end else begin
      if (wr_tab20) rtable20_r <= fgc_merge(rtable20_r, wb_dat_i, wb_sel_i);
      else if (empty_hit) rtable20_r <= tab20_nxt;
      if (wr_tab30) rtable30_r <= fgc_merge(rtable30_r, wb_dat_i, wb_sel_i);
      else if (empty_hit) rtable30_r <= tab30_nxt;
      if (wr_avg) empty_avg_r <= fgc_merge(empty_avg_r, wb_dat_i, wb_sel_i);
      else if (empty_hit) empty_avg_r <= avg_nxt;
    end
  end

  // conversion results, one cycle after the sample strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      temp_res_r <= 16'h0000;
      cur_res_r  <= 16'h0000;
    end else begin
      if (temp_sample_i)
        temp_res_r <= fgc_scale(thermistor_input_reading_i,
                                temp_gain_value_r,
                                temp_offset_value_r);
      if (current_sample_i)
        cur_res_r <= fgc_scale(current_reading_i, current_gain_value_r,
                               current_offset_value_r);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      armed_r      <= 1'b1;
      empty_evt_r  <= 1'b0;
      learn_mode_r <= FGC_LEARN_NONE;
      irq_status_r <= '0;
      irq_enable_r <= '0;
    end else begin
      if (empty_hit) armed_r <= 1'b0;
      else if (recover_hit) armed_r <= 1'b1;
      empty_evt_r <= empty_hit;
      if (empty_hit) learn_mode_r <= learn_nxt;
      irq_status_r <= irq_nxt;
      if (wr_en && wb_sel_i[0]) irq_enable_r <= wb_dat_i[IRQ_BITS-1:0];
    end
  end

  assign wb_ack_o                        = ack_r;
  assign wb_dat_o                        = dat_r;
  assign temp_result_o                   = temp_res_r;
  assign current_result_o                = cur_res_r;
  assign hot_coefficient_o               = temp_coef_r[15:8];
  assign cold_coefficient_o              = temp_coef_r[7:0];
  assign nominal_resistance_comp_field_o = nom_rcomp_r;
  assign empty_event_o                   = empty_evt_r;
  assign learn_mode_o                    = learn_mode_r;
  assign irq_o                           = |(irq_status_r & irq_enable_r);

  default clocking fgc_cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // the product is widened first so no bits drop before the shift
  temp_conv_a: assert property (temp_sample_i |=> temp_res_r ==
    16'((32'($signed($past(thermistor_input_reading_i))) *
    $signed($past(temp_gain_value_r))) >>> 14) +
    16'($signed($past(temp_offset_value_r)) * 2))
    else $error("temperature result wrong");
  cur_conv_a: assert property (current_sample_i && !wr_current_gain_value &&
    !wr_current_offset_value |=> cur_res_r ==
    16'((32'($signed($past(current_reading_i))) *
    $signed(current_gain_value_r)) >>> 14) +
    16'($signed(current_offset_value_r) * 2))
    else $error("current result wrong");
  reset_dflt_a: assert property (disable iff (1'b0)
    $past(reset_i) && !reset_i |-> current_gain_value_r == 16'h4000 &&
    current_offset_value_r == 16'h0000 &&
    empty_thr_r == 16'h9c5c)
    else $error("reset value wrong");
  empty_once_a: assert property (empty_evt_r |-> !armed_r ##1
    !empty_evt_r)
    else $error("empty detected twice without recovery");
  rearm_a: assert property (recover_hit |=> armed_r && !empty_evt_r)
    else $error("recovery did not rearm");
  rcomp_hi_a: assert property (ack_r && !$past(wb_we_i) &&
    $past(idx) == 9'h038 |-> wb_dat_o[15:8] == 8'h00)
    else $error("spare rcomp byte not zero");
  avg_step_a: assert property (empty_hit && !wr_avg |=> empty_avg_r ==
    16'($signed($past(empty_avg_r)) + ($past(cur_diff) >>> 2)))
    else $error("empty current average not updated");
  table_pair_a: assert property (empty_hit && !wr_tab20 && !wr_tab30
    |=> 16'(rtable20_r + rtable30_r) ==
    16'($past(rtable20_r) + $past(rtable30_r) + $past(learn_delta_i)))
    else $error("table pair did not absorb correction");
  coef_split_a: assert property (hot_coefficient_o == temp_coef_r[15:8]
    && $stable(temp_coef_r) || $past(wr_tcoef))
    else $error("coefficient changed without write");
  ack_pulse_a: assert property (ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");
  ack_resp_a: assert property (req && !ack_r |=> ack_r)
    else $error("request not acknowledged");
  ack_idle_a: assert property (!req |=> !ack_r)
    else $error("ack without request");
  // a clear in the same cycle must not swallow a fresh event
  set_wins_a: assert property (empty_hit |=>
    irq_status_r[IRQ_EMPTY] && irq_status_r[IRQ_LEARN])
    else $error("empty status lost");
  rearm_stat_a: assert property (recover_hit |=>
    irq_status_r[IRQ_RECOVER])
    else $error("recover status lost");
  no_empty_a: assert property (!armed_r |=> !empty_evt_r)
    else $error("empty detected while disarmed");
  disarm_a: assert property (empty_hit |=> !armed_r)
    else $error("detection still armed after empty");
  thr_keep_a: assert property (!wr_thr |=> $stable(empty_thr_r))
    else $error("threshold changed without write");
  current_gain_value_keep_a: assert property (!wr_current_gain_value |=>
    $stable(current_gain_value_r))
    else $error("current gain changed without write");
  current_offset_value_keep_a: assert property (!wr_current_offset_value |=>
    $stable(current_offset_value_r))
    else $error("current offset changed without write");
  temp_gain_value_keep_a: assert property (!wr_temp_gain_value |=>
    $stable(temp_gain_value_r))
    else $error("temperature gain changed without write");
  temp_offset_value_keep_a: assert property (!wr_temp_offset_value |=>
    $stable(temp_offset_value_r))
    else $error("temperature offset changed without write");
  mode_hold_a: assert property (!empty_hit |=>
    $stable(learn_mode_r))
    else $error("learn mode changed without empty");
  gain_pick_a: assert property (empty_hit && cur_diff > 17'sd200
    |=> learn_mode_r == FGC_LEARN_GAIN)
    else $error("gain learning not chosen");
  off_pick_a: assert property (empty_hit && cur_diff < -17'sd200
    |=> learn_mode_r == FGC_LEARN_OFFSET)
    else $error("offset learning not chosen");
  avg_hold_a: assert property (!empty_hit && !wr_avg |=>
    $stable(empty_avg_r))
    else $error("average changed without event");
  tab20_hold_a: assert property (!empty_hit && !wr_tab20 |=>
    $stable(rtable20_r))
    else $error("table entry 20 changed without event");
  tab30_hold_a: assert property (!empty_hit && !wr_tab30 |=>
    $stable(rtable30_r))
    else $error("table entry 30 changed without event");
  tres_hold_a: assert property (!temp_sample_i |=>
    $stable(temp_res_r))
    else $error("temperature result changed without sample");
  cres_hold_a: assert property (!current_sample_i |=>
    $stable(cur_res_r))
    else $error("current result changed without sample");
  rcomp_keep_a: assert property (!wr_rcomp |=>
    $stable(nom_rcomp_r))
    else $error("comp value changed without write");

  empty_c:   cover property (empty_hit);
  recover_c: cover property (empty_evt_r ##[1:50] recover_hit);
  irq_c:     cover property (irq_o ##1 wr_clr);
  learn_c:   cover property (empty_hit && learn_nxt == FGC_LEARN_GAIN);
  rearm_c:   cover property (recover_hit ##[1:100] empty_hit);
endmodule : fgc_regs
`default_nettype wire
